// ==== afch_defs.svh ====
// Constants shared by both ends of the format command handler
`ifndef AFCH_DEFS_SVH
`define AFCH_DEFS_SVH

// ********************************************************************
// Command codes and feature values
// ********************************************************************
`define AFCH_CMD_FMT_TRACK 8'h50
`define AFCH_CMD_FMT_UNIT 8'hF7
`define AFCH_CMD_ERASE_PREP 8'hF3
`define AFCH_FEAT_UNIT 8'h11
`define AFCH_FEAT_NONE 8'h00

// ********************************************************************
// Task-file register selects
// ********************************************************************
`define AFCH_SEL_FEATURE 3'h1
`define AFCH_SEL_SECTOR 3'h3
`define AFCH_SEL_CYL_LO 3'h4
`define AFCH_SEL_CYL_HI 3'h5
`define AFCH_SEL_DEVHEAD 3'h6
`define AFCH_SEL_COMMAND 3'h7

// ********************************************************************
// Status, error and device/head fields
// ********************************************************************
`define AFCH_ST_BUSY 7
`define AFCH_ST_READY 6
`define AFCH_ST_FAULT 5
`define AFCH_ST_SEEK 4
`define AFCH_ST_XFER 3
`define AFCH_ST_ERR 0
`define AFCH_ER_IDNF 4
`define AFCH_ER_ABORT 2
`define AFCH_DH_LBA 6
`define AFCH_STATUS_RST 8'h50
`define AFCH_DEVHEAD_RST 8'hA0

// ********************************************************************
// Controller register offsets and reset values
// ********************************************************************
`define AFCH_OFS_CMD 8'h00
`define AFCH_OFS_ADDR 8'h04
`define AFCH_OFS_TIMEOUT 8'h08
`define AFCH_OFS_STATUS 8'h0C
`define AFCH_OFS_RESULT 8'h10
`define AFCH_OFS_TABLE 8'h14
`define AFCH_ADDR_LBA_BIT 30
`define AFCH_STS_BUSY_BIT 16
`define AFCH_STS_TMO_BIT 17
`define AFCH_STS_DONE_BIT 18
`define AFCH_TIMEOUT_RST 32'h0100_0000

`endif

// ==== afch_pkg.sv ====
// Types shared by both ends of the format command handler
`default_nettype none

package afch_pkg;

    typedef enum logic [2:0] {
        AFCH_D_IDLE = 3'b000,
        AFCH_D_MERGE = 3'b001,
        AFCH_D_ZERO = 3'b010,
        AFCH_D_DONE = 3'b011
    } afch_dev_state_t;

    typedef enum logic [2:0] {
        AFCH_H_IDLE = 3'b000,
        AFCH_H_SEND = 3'b001,
        AFCH_H_WAIT = 3'b010
    } afch_host_state_t;

endpackage : afch_pkg

`default_nettype wire

// ==== afch_if.sv ====
// Task-file link between host controller and drive
`default_nettype none

interface afch_if;
    logic tf_wr;
    logic [2:0] tf_sel;
    logic [7:0] tf_wdata;
    logic dat_wr;
    logic [7:0] dat_byte;
    logic [7:0] tf_status;
    logic [7:0] tf_error;
    logic [7:0] tf_sector;
    logic [7:0] tf_cyl_lo;
    logic [7:0] tf_cyl_hi;
    logic [7:0] tf_devhead;

    modport dev (
        input tf_wr, tf_sel, tf_wdata, dat_wr, dat_byte,
        output tf_status, tf_error, tf_sector, tf_cyl_lo, tf_cyl_hi, tf_devhead
    );

    modport host (
        output tf_wr, tf_sel, tf_wdata, dat_wr, dat_byte,
        input tf_status, tf_error, tf_sector, tf_cyl_lo, tf_cyl_hi, tf_devhead
    );
endinterface : afch_if

`default_nettype wire

// ==== afch_dev.sv ====
// Drive end: decodes and runs the track and unit format commands
//
// Operation
// [R1] Command 50h runs the track format
// [R2] Track format writes zero to each sector
// [R3] No read-back check after zero fill
// [R4] Host may send one format table sector
// [R5] Format table descriptors are ignored entirely
// [R6] Track layout always 1:1, numbering ignored
// [R7] LBA built from sector, cylinder, head fields
// [R8] CHS mode: cylinder registers and head field
// [R9] LBA mode formats whole containing track
// [R10] LBA mode returns current LBA on completion
// [R11] LBA out of range aborts track format
// [R12] Command F7h runs the unit format
// [R13] Merge reassignments into defects, then zero fill
// [R14] New defect lists usable, old ones erased
// [R15] Unit format covers LBA 0 to native max
// [R16] Unit format aborts without prior erase prepare
// [R17] Host issues erase prepare right before
// [R18] Host writes feature 11h for unit format
// [R19] Unit format has no data transfer phase
// [R20] Host timeout derived from identify word 89
// [R21] Completion clears busy, error sets summary
`include "afch_defs.svh"
`default_nettype none

module afch_dev
    import afch_pkg::*;
#(
    parameter int SPT = 63,
    parameter int HEADS = 16,
    parameter int CYLS = 16383,
    parameter logic [27:0] NATIVE_MAX_LBA = 28'h0FFFFFF
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Task-file link
    afch_if.dev TF,
    // Media zero-write engine
    output logic MW_REQ,
    output logic [27:0] MW_LBA,
    input wire logic MW_ACK,
    // Defect list maintenance
    output logic DL_MERGE_REQ,
    input wire logic DL_MERGE_ACK
);

    // ****************************************************************
    // Address arithmetic
    // ****************************************************************
    function automatic logic [27:0] chs_to_lba(input logic [15:0] cyl, input logic [3:0] head);
        logic [27:0] trk;
        trk = 28'({12'h000, cyl} * 28'(HEADS)) + {24'h000000, head};
        return 28'(trk * 28'(SPT));
    endfunction

    afch_dev_state_t state_ff;
    logic [7:0] feature_ff;
    logic [7:0] sector_ff;
    logic [7:0] cyl_lo_ff;
    logic [7:0] cyl_hi_ff;
    logic [7:0] devhead_ff;
    logic [7:0] status_ff;
    logic [7:0] error_ff;
    logic [7:0] err_pend_ff;
    logic prep_ff;
    logic lba_mode_ff;
    logic [27:0] cur_ff;
    logic [27:0] last_ff;
    logic mw_req_ff;
    logic merge_req_ff;

    logic cmd_wr;
    logic [27:0] req_lba;
    logic [27:0] chs_start;
    logic [27:0] lba_start;
    logic chs_bad;

    assign cmd_wr = TF.tf_wr && (TF.tf_sel == `AFCH_SEL_COMMAND) && (state_ff == AFCH_D_IDLE);
    assign req_lba = {devhead_ff[3:0], cyl_hi_ff, cyl_lo_ff, sector_ff}; // [R7]
    assign lba_start = req_lba - (req_lba % 28'(SPT)); // [R9]
    assign chs_start = chs_to_lba({cyl_hi_ff, cyl_lo_ff}, devhead_ff[3:0]); // [R8]
    assign chs_bad = ({cyl_hi_ff, cyl_lo_ff} >= 16'(CYLS)) || ({4'h0, devhead_ff[3:0]} >= 8'(HEADS))
                     || (chs_start > NATIVE_MAX_LBA);

    // ****************************************************************
    // Command state machine
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= AFCH_D_IDLE;
            err_pend_ff <= 8'h00;
            lba_mode_ff <= 1'b0;
            cur_ff <= 28'h0000000;
            last_ff <= 28'h0000000;
        end else begin
            case (state_ff)
                AFCH_D_IDLE: begin
                    if (cmd_wr) begin
                        err_pend_ff <= 8'h00;
                        lba_mode_ff <= devhead_ff[`AFCH_DH_LBA];
                        state_ff <= AFCH_D_DONE;
                        if (TF.tf_wdata == `AFCH_CMD_FMT_TRACK) begin // [R1]
                            if (devhead_ff[`AFCH_DH_LBA]) begin
                                if (req_lba > NATIVE_MAX_LBA) begin
                                    err_pend_ff <= 8'h01 << `AFCH_ER_ABORT; // [R11]
                                end else begin
                                    // Sequential 1:1 run over the track's LBAs [R6]
                                    cur_ff <= lba_start;
                                    last_ff <= lba_start + 28'(SPT - 1);
                                    state_ff <= AFCH_D_ZERO;
                                end
                            end else if (chs_bad) begin
                                err_pend_ff <= 8'h01 << `AFCH_ER_IDNF;
                            end else begin
                                cur_ff <= chs_start;
                                last_ff <= chs_start + 28'(SPT - 1);
                                state_ff <= AFCH_D_ZERO;
                            end
                        end else if (TF.tf_wdata == `AFCH_CMD_FMT_UNIT) begin // [R12]
                            if (!prep_ff) begin
                                err_pend_ff <= 8'h01 << `AFCH_ER_ABORT; // [R16]
                            end else begin
                                state_ff <= AFCH_D_MERGE; // [R13]
                            end
                        end
                    end
                end
                AFCH_D_MERGE: begin
                    if (DL_MERGE_ACK) begin
                        // Defect lists are final here; zero fill spans the native range [R14]
                        cur_ff <= 28'h0000000; // [R15]
                        last_ff <= NATIVE_MAX_LBA; // [R15]
                        state_ff <= AFCH_D_ZERO;
                    end
                end
                AFCH_D_ZERO: begin
                    // Each ack ends a sector; no verify pass follows [R3]
                    if (MW_ACK) begin
                        if (cur_ff == last_ff) begin
                            state_ff <= AFCH_D_DONE;
                        end else begin
                            cur_ff <= cur_ff + 28'h0000001;
                        end
                    end
                end
                AFCH_D_DONE: begin
                    state_ff <= AFCH_D_IDLE;
                end
                default: begin
                    state_ff <= AFCH_D_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Erase-prepare tracking
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            prep_ff <= 1'b0;
        end else if (cmd_wr) begin
            prep_ff <= (TF.tf_wdata == `AFCH_CMD_ERASE_PREP); // [R16]
        end
    end

    // ****************************************************************
    // Media and defect requests
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mw_req_ff <= 1'b0;
            merge_req_ff <= 1'b0;
        end else begin
            // Zero writes only, media skips defective sectors [R2]
            mw_req_ff <= (state_ff == AFCH_D_ZERO) && !(MW_ACK && (cur_ff == last_ff)); // [R2]
            merge_req_ff <= (state_ff == AFCH_D_MERGE) && !DL_MERGE_ACK; // [R13]
        end
    end

    // ****************************************************************
    // Task-file registers
    // ****************************************************************
    // Format table bytes on dat_wr are never sampled [R5]
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            feature_ff <= 8'h00;
            sector_ff <= 8'h00;
            cyl_lo_ff <= 8'h00;
            cyl_hi_ff <= 8'h00;
            devhead_ff <= `AFCH_DEVHEAD_RST;
        end else if (state_ff == AFCH_D_DONE) begin
            if (lba_mode_ff && (err_pend_ff == 8'h00)) begin
                sector_ff <= cur_ff[7:0]; // [R10]
                cyl_lo_ff <= cur_ff[15:8]; // [R10]
                cyl_hi_ff <= cur_ff[23:16]; // [R10]
                devhead_ff <= {devhead_ff[7:4], cur_ff[27:24]}; // [R10]
            end
        end else if (TF.tf_wr && (state_ff == AFCH_D_IDLE)) begin
            case (TF.tf_sel)
                `AFCH_SEL_FEATURE: feature_ff <= TF.tf_wdata;
                `AFCH_SEL_SECTOR: sector_ff <= TF.tf_wdata;
                `AFCH_SEL_CYL_LO: cyl_lo_ff <= TF.tf_wdata;
                `AFCH_SEL_CYL_HI: cyl_hi_ff <= TF.tf_wdata;
                `AFCH_SEL_DEVHEAD: devhead_ff <= TF.tf_wdata;
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Status and error
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_ff <= `AFCH_STATUS_RST;
            error_ff <= 8'h00;
        end else if (cmd_wr) begin
            status_ff <= 8'h01 << `AFCH_ST_BUSY;
            error_ff <= 8'h00;
        end else if (state_ff == AFCH_D_DONE) begin
            // Transfer request bit stays clear throughout [R19]
            status_ff <= (8'h01 << `AFCH_ST_READY) | (8'h01 << `AFCH_ST_SEEK)
                         | {7'h00, (err_pend_ff != 8'h00)}; // [R21]
            error_ff <= err_pend_ff; // [R21]
        end
    end

    assign TF.tf_status = status_ff;
    assign TF.tf_error = error_ff;
    assign TF.tf_sector = sector_ff;
    assign TF.tf_cyl_lo = cyl_lo_ff;
    assign TF.tf_cyl_hi = cyl_hi_ff;
    assign TF.tf_devhead = devhead_ff;
    assign MW_REQ = mw_req_ff;
    assign MW_LBA = cur_ff;
    assign DL_MERGE_REQ = merge_req_ff;

endmodule : afch_dev

`default_nettype wire

// ==== afch_host.sv ====
// Host end: APB-programmed controller that issues format commands
`include "afch_defs.svh"
`default_nettype none

module afch_host
    import afch_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Task-file link
    afch_if.host TF
);

    afch_host_state_t state_ff;
    logic [31:0] addr_ff;
    logic [31:0] timeout_ff;
    logic [31:0] wait_cnt_ff;
    logic [7:0] op_ff;
    logic prep_phase_ff;
    logic [2:0] idx_ff;
    logic tmo_ff;
    logic done_ff;
    logic tf_wr_ff;
    logic [2:0] tf_sel_ff;
    logic [7:0] tf_wdata_ff;
    logic dat_wr_ff;
    logic [7:0] dat_byte_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    logic wr_acc;
    logic busy;
    logic cmd_go;
    logic wait_end;
    logic mapped;

    assign wr_acc = PSEL && PENABLE && pready_ff && PWRITE;
    assign busy = (state_ff != AFCH_H_IDLE);
    assign mapped = (PADDR == `AFCH_OFS_CMD) || (PADDR == `AFCH_OFS_ADDR)
                    || (PADDR == `AFCH_OFS_TIMEOUT) || (PADDR == `AFCH_OFS_STATUS)
                    || (PADDR == `AFCH_OFS_RESULT) || (PADDR == `AFCH_OFS_TABLE);
    assign cmd_go = wr_acc && (PADDR == `AFCH_OFS_CMD) && !busy
                    && ((PWDATA[7:0] == `AFCH_CMD_FMT_TRACK) || (PWDATA[7:0] == `AFCH_CMD_FMT_UNIT));
    // Drive takes the command one edge into the wait, so busy is read only after that
    assign wait_end = (state_ff == AFCH_H_WAIT) && (wait_cnt_ff != 32'h0000_0000)
                      && (!TF.tf_status[`AFCH_ST_BUSY] || (wait_cnt_ff >= timeout_ff));

    // ****************************************************************
    // Task-file byte for each step of the send sequence
    // ****************************************************************
    function automatic logic [7:0] step_byte(input logic [2:0] idx, input logic [31:0] adr,
                                             input logic [7:0] op, input logic prep);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            3'h0: b = (op == `AFCH_CMD_FMT_UNIT) ? `AFCH_FEAT_UNIT : `AFCH_FEAT_NONE; // [R18]
            3'h1: b = adr[7:0];
            3'h2: b = adr[15:8];
            3'h3: b = adr[23:16];
            3'h4: b = {1'b1, adr[`AFCH_ADDR_LBA_BIT], 1'b1, 1'b0, adr[27:24]}; // [R7] [R8]
            default: b = prep ? `AFCH_CMD_ERASE_PREP : op;
        endcase
        return b;
    endfunction

    function automatic logic [2:0] step_sel(input logic [2:0] idx);
        logic [2:0] s;
        case (idx)
            3'h0: s = `AFCH_SEL_FEATURE;
            3'h1: s = `AFCH_SEL_SECTOR;
            3'h2: s = `AFCH_SEL_CYL_LO;
            3'h3: s = `AFCH_SEL_CYL_HI;
            3'h4: s = `AFCH_SEL_DEVHEAD;
            default: s = `AFCH_SEL_COMMAND;
        endcase
        return s;
    endfunction

    // ****************************************************************
    // Command sequencer
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= AFCH_H_IDLE;
            op_ff <= 8'h00;
            prep_phase_ff <= 1'b0;
            idx_ff <= 3'h0;
            wait_cnt_ff <= 32'h0000_0000;
        end else begin
            case (state_ff)
                AFCH_H_IDLE: begin
                    if (cmd_go) begin
                        op_ff <= PWDATA[7:0];
                        // Unit format is preceded by erase prepare [R17]
                        prep_phase_ff <= (PWDATA[7:0] == `AFCH_CMD_FMT_UNIT); // [R17]
                        idx_ff <= (PWDATA[7:0] == `AFCH_CMD_FMT_UNIT) ? 3'h5 : 3'h0;
                        state_ff <= AFCH_H_SEND;
                    end
                end
                AFCH_H_SEND: begin
                    if (idx_ff == 3'h5) begin
                        wait_cnt_ff <= 32'h0000_0000;
                        state_ff <= AFCH_H_WAIT;
                    end else begin
                        idx_ff <= idx_ff + 3'h1;
                    end
                end
                AFCH_H_WAIT: begin
                    wait_cnt_ff <= wait_cnt_ff + 32'h0000_0001;
                    if (wait_end) begin
                        if (prep_phase_ff && (wait_cnt_ff < timeout_ff) && !TF.tf_status[`AFCH_ST_ERR]) begin
                            prep_phase_ff <= 1'b0;
                            idx_ff <= 3'h0;
                            state_ff <= AFCH_H_SEND;
                        end else begin
                            state_ff <= AFCH_H_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= AFCH_H_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Link drive
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tf_wr_ff <= 1'b0;
            tf_sel_ff <= 3'h0;
            tf_wdata_ff <= 8'h00;
            dat_wr_ff <= 1'b0;
            dat_byte_ff <= 8'h00;
        end else begin
            tf_wr_ff <= (state_ff == AFCH_H_SEND);
            tf_sel_ff <= step_sel(idx_ff);
            tf_wdata_ff <= step_byte(idx_ff, addr_ff, op_ff, prep_phase_ff);
            // Optional format table bytes, only while idle [R4]
            dat_wr_ff <= wr_acc && (PADDR == `AFCH_OFS_TABLE) && !busy; // [R4]
            dat_byte_ff <= PWDATA[7:0];
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_ff <= 32'h0000_0000;
            timeout_ff <= `AFCH_TIMEOUT_RST;
        end else if (wr_acc && (PADDR == `AFCH_OFS_ADDR)) begin
            addr_ff <= PWDATA;
        end else if (wr_acc && (PADDR == `AFCH_OFS_TIMEOUT)) begin
            // Software loads this from identify word 89 [R20]
            timeout_ff <= PWDATA; // [R20]
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tmo_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            if (wait_end && (wait_cnt_ff >= timeout_ff)) begin
                tmo_ff <= 1'b1;
            end else if (wr_acc && (PADDR == `AFCH_OFS_STATUS) && PWDATA[`AFCH_STS_TMO_BIT]) begin
                tmo_ff <= 1'b0;
            end
            if (wait_end && !prep_phase_ff) begin
                done_ff <= 1'b1;
            end else if (wait_end && TF.tf_status[`AFCH_ST_ERR]) begin
                done_ff <= 1'b1;
            end else if (wr_acc && (PADDR == `AFCH_OFS_STATUS) && PWDATA[`AFCH_STS_DONE_BIT]) begin
                done_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // APB response
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= PSEL && !PENABLE;
            pslverr_ff <= PSEL && !PENABLE && !mapped;
            prdata_ff <= 32'h0000_0000;
            if (PSEL && !PENABLE && !PWRITE) begin
                case (PADDR)
                    `AFCH_OFS_ADDR: prdata_ff <= addr_ff;
                    `AFCH_OFS_TIMEOUT: prdata_ff <= timeout_ff;
                    `AFCH_OFS_STATUS: prdata_ff <= {13'h0000, done_ff, tmo_ff, busy,
                                                    TF.tf_error, TF.tf_status};
                    `AFCH_OFS_RESULT: prdata_ff <= {TF.tf_devhead, TF.tf_cyl_hi,
                                                    TF.tf_cyl_lo, TF.tf_sector};
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign TF.tf_wr = tf_wr_ff;
    assign TF.tf_sel = tf_sel_ff;
    assign TF.tf_wdata = tf_wdata_ff;
    assign TF.dat_wr = dat_wr_ff;
    assign TF.dat_byte = dat_byte_ff;

endmodule : afch_host

`default_nettype wire

// ==== afch_asserts.sv ====
// Link checks for the format command handler
`include "afch_defs.svh"
`default_nettype none
module afch_asserts (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Task-file link
    input wire logic tf_wr,
    input wire logic [2:0] tf_sel,
    input wire logic [7:0] tf_wdata,
    input wire logic [7:0] tf_status,
    input wire logic [7:0] tf_error,
    input wire logic [7:0] tf_sector
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] feat_ff;
    logic [7:0] last_cmd_ff;
    logic cmd_wr;
    assign cmd_wr = tf_wr && tf_sel == `AFCH_SEL_COMMAND && !tf_status[7];
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            feat_ff <= 8'h00;
            last_cmd_ff <= 8'h00;
        end else begin
            if (tf_wr && tf_sel == `AFCH_SEL_FEATURE) feat_ff <= tf_wdata;
            if (cmd_wr) last_cmd_ff <= tf_wdata;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    cmd_busy_a: assert property (cmd_wr |=> tf_status[7]) else $error("busy not raised");
    unit_feat_a: assert property (cmd_wr && tf_wdata == 8'hF7 |-> feat_ff == 8'h11)
        else $error("bad feature");
    prep_first_a: assert property (cmd_wr && tf_wdata == 8'hF7 |-> last_cmd_ff == 8'hF3)
        else $error("no prepare");
    xfer_clear_a: assert property (!tf_status[3]) else $error("transfer bit set");
    err_sum_a: assert property (!tf_status[7] |-> tf_status[0] == (tf_error != 8'h00))
        else $error("summary error wrong");
    done_ready_a: assert property ($fell(tf_status[7]) |-> tf_status[6] && tf_status[4])
        else $error("ready missing");
    result_hold_a: assert property (!tf_status[7] && !tf_wr |=> $stable(tf_sector))
        else $error("result moved");
    devhead_form_a: assert property (tf_wr && tf_sel == 3'h6 |-> tf_wdata[7] && tf_wdata[5])
        else $error("bad device head byte");
endmodule // afch_asserts
`default_nettype wire

// ==== ata_format_command_handler_tb.sv ====
// Bench: APB-driven format runs across host and drive ends
`include "afch_defs.svh"
`default_nettype none
module ata_format_command_handler_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, mw_req, mw_ack, dl_req, dl_ack, err, mfirst;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, first_lba, last_lba;
    logic [27:0] mw_lba;
    int bad_count, checks, nacc, merges;
    always #10 CLK = ~CLK;
    afch_if link();
    afch_dev #(.SPT(4), .HEADS(2), .CYLS(8), .NATIVE_MAX_LBA(28'h3F)) afch_dev_inst (
        .CLK(CLK), .ARST_N(ARST_N), .TF(link), .MW_REQ(mw_req), .MW_LBA(mw_lba),
        .MW_ACK(mw_ack), .DL_MERGE_REQ(dl_req), .DL_MERGE_ACK(dl_ack));
    afch_host afch_host_inst (.CLK(CLK), .ARST_N(ARST_N), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TF(link));
    afch_asserts afch_asserts_inst (.CLK(CLK), .ARST_N(ARST_N), .tf_wr(link.tf_wr),
        .tf_sel(link.tf_sel), .tf_wdata(link.tf_wdata), .tf_status(link.tf_status),
        .tf_error(link.tf_error), .tf_sector(link.tf_sector));
    // ****************
    // Media ends
    // ****************
    always @(posedge CLK) begin
        mw_ack <= mw_req && !mw_ack;
        dl_ack <= dl_req && !dl_ack;
        if (dl_req && dl_ack) merges <= merges + 1;
        if (mw_req && mw_ack) begin
            if (nacc == 0) first_lba <= {4'h0, mw_lba};
            if (nacc == 0) mfirst <= (merges != 0);
            last_lba <= {4'h0, mw_lba};
            nacc <= nacc + 1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic final_report;
        $display("mismatches %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge CLK);
            if (pready === 1'b1) break;
        end
        if (k == 20) bad_count++;
        if (k == 20) final_report;
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic fmt(input logic [31:0] adr, input logic [7:0] cmd);
        int k;
        nacc = 0;
        merges = 0;
        apb(1'b1, `AFCH_OFS_STATUS, 32'h0006_0000);
        apb(1'b1, `AFCH_OFS_ADDR, adr);
        apb(1'b1, `AFCH_OFS_CMD, {24'h0, cmd});
        for (k = 0; k < 300; k++) begin
            apb(1'b0, `AFCH_OFS_STATUS, 32'h0);
            if (r[18] === 1'b1) break;
        end
        if (k == 300) bad_count++;
        if (k == 300) final_report;
        r = {16'h0, r[15:0]};
    endtask
    initial begin
        {psel, penable, pwrite, mw_ack, dl_ack} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        apb(1'b0, `AFCH_OFS_STATUS, 32'h0);
        chk("status reset", r, 32'h50);
        apb(1'b0, `AFCH_OFS_TIMEOUT, 32'h0);
        chk("timeout reset", r, `AFCH_TIMEOUT_RST);
        apb(1'b1, `AFCH_OFS_TIMEOUT, 32'h0000_0200);
        apb(1'b0, `AFCH_OFS_TIMEOUT, 32'h0);
        chk("timeout load", r, 32'h0000_0200);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(1'b1, `AFCH_OFS_TABLE, 32'hA5);
        fmt(32'h0100_0300, 8'h50);
        chk("chs result", r, 32'h50);
        chk("chs count", nacc, 32'h4);
        chk("chs start", first_lba, 32'd28);
        chk("chs end", last_lba, 32'd31);
        fmt(32'h4000_002A, 8'h50);
        chk("lba count", nacc, 32'h4);
        chk("lba start", first_lba, 32'd40);
        apb(1'b0, `AFCH_OFS_RESULT, 32'h0);
        chk("lba back", {4'h0, r[27:0]}, 32'd43);
        fmt(32'h4000_0050, 8'h50);
        chk("lba range", r, 32'h0451);
        chk("no writes", nacc, 32'h0);
        fmt(32'h0000_0800, 8'h50);
        chk("chs range", r, 32'h1051);
        fmt(32'h0, 8'hF7);
        chk("unit result", r, 32'h50);
        chk("merges", merges, 32'h1);
        chk("merge first", {31'h0, mfirst}, 32'h1);
        chk("unit count", nacc, 32'd64);
        chk("unit ends", {first_lba[15:0], last_lba[15:0]}, 32'h3F);
        final_report;
    end
endmodule // ata_format_command_handler_tb
`default_nettype wire
